// ---- nvsc_ctrl.sv ----
// host-side pin controller for a 32K x 8 sram with nonvolatile shadow cells
// assumes supply_low_in comes from a supply monitor and the memory pins are asynchronous
`timescale 1ns/1ps
module nvsc_ctrl
  import nvsc_pkg::*;
#(
  parameter int unsigned SAVE_CYCLES  = SAVE_CYC,
  parameter int unsigned PWRUP_CYCLES = PWRUP_CYC
) (
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              cmd_valid_in,
  input  wire logic [1:0]        cmd_op_in,
  input  wire logic [ADDR_W-1:0] cmd_addr_in,
  input  wire logic [DATA_W-1:0] cmd_wdata_in,
  output logic                   cmd_ready_out,
  output logic                   rsp_valid_out,
  output logic      [DATA_W-1:0] rsp_rdata_out,
  output logic                   busy_out,
  input  wire logic              supply_low_in,
  output logic                   select_n_out,
  output logic                   write_strobe_n_out,
  output logic                   output_gate_n_out,
  output logic      [ADDR_W-1:0] addr_lines_out,
  input  wire logic [DATA_W-1:0] data_lines_in,
  output logic      [DATA_W-1:0] data_lines_out,
  output logic                   data_lines_oe_out
);
  nvsc_state_t       state_r;
  nvsc_state_t       state_nxt;
  logic [DATA_W-1:0] data_s;
  logic              supply_low_s;
  logic              accept;
  logic              wr_eff;
  logic              seq_eff;
  logic              wr_r;
  logic              seq_r;
  logic              rcl_r;
  logic [2:0]        step_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [TMR_W-1:0]  tmr_r;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  nvsc_sync #(.W(DATA_W)) u_data_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (data_lines_in),
    .q_out    (data_s)
  );
  nvsc_sync #(.W(1)) u_supply_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (supply_low_in),
    .q_out    (supply_low_s)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // sequencing
  assign accept  = cmd_valid_in && cmd_ready_out;
  assign wr_eff  = accept ? (cmd_op_in == OP_WRITE) : wr_r;
  assign seq_eff = accept ? cmd_op_in[1] : seq_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_PWRUP: begin
        if (!supply_low_s && tmr_r == '0) begin
          state_nxt = S_IDLE;
        end
      end
      S_IDLE: begin
        if (accept) begin
          state_nxt = S_SETUP;
        end else if (supply_low_s) begin
          state_nxt = S_PWRUP;
        end
      end
      S_SETUP: begin
        if (seq_r && supply_low_s) begin
          state_nxt = S_PWRUP;
        end else begin
          state_nxt = S_STROBE;
        end
      end
      S_STROBE: begin
        if (cnt_r == '0) begin
          state_nxt = S_HOLD;
        end
      end
      S_HOLD: begin
        if (!seq_r) begin
          state_nxt = S_IDLE;
        end else if (supply_low_s) begin
          state_nxt = S_PWRUP;
        end else if (step_r == 3'(SEQ_LAST)) begin
          state_nxt = S_WAIT;
        end else begin
          state_nxt = S_SETUP;
        end
      end
      S_WAIT: begin
        if (supply_low_s) begin
          state_nxt = S_PWRUP;
        end else if (tmr_r == '0) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_PWRUP;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r       <= S_PWRUP;
      cmd_ready_out <= 1'b0;
      busy_out      <= 1'b1;
    end else begin
      state_r       <= state_nxt;
      cmd_ready_out <= (state_nxt == S_IDLE) && !accept;
      busy_out      <= (state_nxt != S_IDLE) || accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // request latch and sequence step
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_r           <= 1'b0;
      seq_r          <= 1'b0;
      rcl_r          <= 1'b0;
      step_r         <= 3'h0;
      addr_lines_out <= '0;
      data_lines_out <= '0;
    end else if (accept) begin
      wr_r   <= (cmd_op_in == OP_WRITE);
      seq_r  <= cmd_op_in[1];
      rcl_r  <= (cmd_op_in == OP_RESTORE);
      step_r <= 3'h0;
      if (cmd_op_in[1]) begin
        addr_lines_out <= {1'b0, nvsc_seq_addr(3'h0, cmd_op_in[0])};
      end else begin
        addr_lines_out <= cmd_addr_in;
      end
      data_lines_out <= cmd_wdata_in;
    end else if (state_r == S_HOLD && state_nxt == S_SETUP) begin
      step_r         <= step_r + 3'h1;
      addr_lines_out <= {1'b0, nvsc_seq_addr(step_r + 3'h1, rcl_r)};
    end else if (state_nxt == S_IDLE || state_nxt == S_PWRUP) begin
      seq_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // strobe counter and transfer timer
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r <= '0;
    end else if (state_nxt == S_STROBE && state_r != S_STROBE) begin
      cnt_r <= wr_r ? CNT_W'(ACC_CYC - 1) : CNT_W'(RD_CYC - 1);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tmr_r <= TMR_W'(PWRUP_CYCLES - 1);
    end else if (supply_low_s || (state_nxt == S_PWRUP && state_r != S_PWRUP)) begin
      tmr_r <= TMR_W'(PWRUP_CYCLES - 1);
    end else if (state_nxt == S_WAIT && state_r != S_WAIT) begin
      tmr_r <= rcl_r ? TMR_W'(RESTORE_CYC - 1) : TMR_W'(SAVE_CYCLES - 1);
    end else if (tmr_r != '0) begin
      tmr_r <= tmr_r - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // memory pins
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      select_n_out       <= 1'b1;
      write_strobe_n_out <= 1'b1;
      output_gate_n_out  <= 1'b1;
      data_lines_oe_out  <= 1'b0;
    end else begin
      select_n_out       <= !(state_nxt == S_STROBE);
      write_strobe_n_out <= !(state_nxt == S_STROBE && wr_eff && !seq_eff);
      output_gate_n_out  <= !(state_nxt == S_STROBE && !wr_eff && !seq_eff);
      data_lines_oe_out  <= wr_eff && (state_nxt == S_SETUP || state_nxt == S_STROBE
                            || state_nxt == S_HOLD);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end else begin
      rsp_valid_out <= (state_r == S_HOLD && !seq_r) || (state_r == S_WAIT && state_nxt == S_IDLE);
      if (state_r == S_STROBE && cnt_r == '0 && !wr_r && !seq_r) begin
        rsp_rdata_out <= data_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  a_write_gate_high: assert property (!write_strobe_n_out |-> output_gate_n_out)
    else $error("gate low during write");
  a_write_addr_hold: assert property ($rose(write_strobe_n_out) |->
    $stable(addr_lines_out) && data_lines_oe_out)
    else $error("address moved at end of write");
  a_write_addr_stable: assert property (!write_strobe_n_out |-> $stable(addr_lines_out))
    else $error("address moved during write");
  a_seq_strobe_high: assert property (seq_r && !select_n_out |-> write_strobe_n_out)
    else $error("write strobe low in sequence");
  a_seq_top_bit: assert property (seq_r && !select_n_out |-> !addr_lines_out[14])
    else $error("top address bit set in sequence");
  a_seq_no_test: assert property (seq_r && !select_n_out |->
    addr_lines_out[13:0] != SEQ_TEST)
    else $error("reserved test address issued");
  a_seq_order: assert property (seq_r && $fell(select_n_out) |->
    addr_lines_out[13:0] == (step_r == 3'h0 ? SEQ_A0 : step_r == 3'h1 ? SEQ_A1 :
    step_r == 3'h2 ? SEQ_A2 : step_r == 3'h3 ? SEQ_A3 : step_r == 3'h4 ? SEQ_A4 :
    rcl_r ? SEQ_RCL : SEQ_SAVE))
    else $error("sequence address out of order");
  a_seq_toggle: assert property (seq_r && $fell(select_n_out) |->
    ##[1:20] $rose(select_n_out))
    else $error("select not toggled per step");
  a_wait_quiet: assert property (state_r == S_WAIT |->
    select_n_out && !data_lines_oe_out)
    else $error("access during transfer");
  a_low_supply_idle: assert property (state_r == S_IDLE && supply_low_s && !accept |=>
    state_r == S_PWRUP)
    else $error("low supply not honoured");
  a_seq_clear_idle: assert property (state_r == S_IDLE |-> !seq_r)
    else $error("sequence left pending");

  c_read_done: cover property (state_r == S_HOLD && !seq_r && !wr_r);
  c_write_done: cover property (state_r == S_HOLD && !seq_r && wr_r);
  c_save_done: cover property (state_r == S_WAIT && !rcl_r ##1 state_r == S_IDLE);
  c_restore_done: cover property (state_r == S_WAIT && rcl_r ##1 state_r == S_IDLE);
endmodule

// ---- nvsc_pkg.sv ----
// constants and types for the nonvolatile sram pin controller, plus its input synchroniser
// assumes a single 125 MHz clock and an asynchronous active-low reset
package nvsc_pkg;
  localparam int unsigned CLK_NS      = 8;
  localparam int unsigned ACC_NS      = 55;
  localparam int unsigned ACC_CYC     = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SYNC_CYC    = 4;
  localparam int unsigned RD_CYC      = ACC_CYC + SYNC_CYC;
  localparam int unsigned RESTORE_NS  = 20000;
  localparam int unsigned RESTORE_CYC = (RESTORE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SAVE_NS     = 10000000;
  localparam int unsigned SAVE_CYC    = (SAVE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PWRUP_NS    = 650000;
  localparam int unsigned PWRUP_CYC   = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TMR_W       = 21;
  localparam int unsigned CNT_W       = 4;
  localparam int unsigned ADDR_W      = 15;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned SEQ_LAST    = 5;
  localparam logic [13:0] SEQ_A0      = 14'h0e38;
  localparam logic [13:0] SEQ_A1      = 14'h31c7;
  localparam logic [13:0] SEQ_A2      = 14'h03e0;
  localparam logic [13:0] SEQ_A3      = 14'h3c1f;
  localparam logic [13:0] SEQ_A4      = 14'h303f;
  localparam logic [13:0] SEQ_SAVE    = 14'h0fc0;
  localparam logic [13:0] SEQ_RCL     = 14'h0c63;
  localparam logic [13:0] SEQ_TEST    = 14'h339c;
  localparam logic [1:0]  OP_READ     = 2'h0;
  localparam logic [1:0]  OP_WRITE    = 2'h1;
  localparam logic [1:0]  OP_SAVE     = 2'h2;
  localparam logic [1:0]  OP_RESTORE  = 2'h3;

  typedef enum logic [2:0] {S_PWRUP, S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_WAIT} nvsc_state_t;

  function automatic logic [13:0] nvsc_seq_addr(input logic [2:0] idx, input logic rcl);
    logic [13:0] a;
    a = rcl ? SEQ_RCL : SEQ_SAVE;
    case (idx)
      3'h0: a = SEQ_A0;
      3'h1: a = SEQ_A1;
      3'h2: a = SEQ_A2;
      3'h3: a = SEQ_A3;
      3'h4: a = SEQ_A4;
      default: a = rcl ? SEQ_RCL : SEQ_SAVE;
    endcase
    return a;
  endfunction
endpackage

////////////////////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module nvsc_sync
  import nvsc_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // three stages per bit; a change counts once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        s1_r[i]  <= 1'b0;
        s2_r[i]  <= 1'b0;
        s3_r[i]  <= 1'b0;
        q_out[i] <= 1'b0;
      end else begin
        s1_r[i] <= d_in[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          q_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// ---- nvsc_mem_model.sv ----
// behavioural model of the 32K x 8 sram with nonvolatile shadow cells, seen at its pins
// assumes the bench resolves the shared data lines and drives supply_low_in
`timescale 1ns/1ps
module nvsc_mem_model
  import nvsc_pkg::*;
#(
  parameter int SAVE_NS    = 300,
  parameter int RESTORE_NS = 19000,
  parameter int PWRUP_NS   = 150
) (
  input  wire logic              select_n_in,
  input  wire logic              write_strobe_n_in,
  input  wire logic              output_gate_n_in,
  input  wire logic [ADDR_W-1:0] addr_lines_in,
  input  wire logic [DATA_W-1:0] data_lines_in,
  input  wire logic              supply_low_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe_out
);
  logic [DATA_W-1:0] sram [0:32767];
  logic [DATA_W-1:0] nv   [0:32767];
  logic [13:0]       seq  [0:4];
  logic [2:0]        step = 3'h0;
  logic              busy = 1'b0;
  logic              dirty = 1'b0;
  logic              wseen = 1'b0;
  wire               wr_act = !select_n_in && !write_strobe_n_in;

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seq = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    for (int i = 0; i < 32768; i++) begin
      nv[i] = 8'h00;
      sram[i] = 8'h00;
    end
  end

  // read port: data follows address while selected and gated
  assign data_oe_out = !busy && !select_n_in && !output_gate_n_in && write_strobe_n_in;
  assign data_out    = sram[addr_lines_in];

  ////////////////////////////////////////////////////////////////////////////////
  // write latched when the first strobe returns high
  always @(posedge wr_act) wseen = 1'b1;
  always @(negedge wr_act) begin
    if (!busy && $time > 0) begin
      sram[addr_lines_in] = data_lines_in;
      dirty = 1'b1;
      step = 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequence detector clocked by select rising
  always @(posedge select_n_in) begin
    if (!busy && !wseen && $time > 0) begin
      if (step == 3'h5 && addr_lines_in[13:0] == SEQ_SAVE && !supply_low_in) begin
        busy = 1'b1;
        step = 3'h0;
        for (int i = 0; i < 32768; i++) nv[i] = 8'hff;
        for (int i = 0; i < 32768; i++) nv[i] = sram[i];
        dirty = 1'b0;
        #(SAVE_NS);
        busy = 1'b0;
      end else if (step == 3'h5 && addr_lines_in[13:0] == SEQ_RCL) begin
        busy = 1'b1;
        step = 3'h0;
        for (int i = 0; i < 32768; i++) sram[i] = 8'h00;
        for (int i = 0; i < 32768; i++) sram[i] = nv[i];
        dirty = 1'b0;
        // restore runs to its end even if the supply drops meanwhile
        #(RESTORE_NS);
        busy = 1'b0;
      end else if (step < 3'h5 && addr_lines_in[13:0] == seq[step]) begin
        step = step + 3'h1;
      end else begin
        step = (addr_lines_in[13:0] == SEQ_A0) ? 3'h1 : 3'h0;
      end
    end
    wseen = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // supply loss saves when written, supply return restores
  always @(posedge supply_low_in) begin
    if (dirty) begin
      for (int i = 0; i < 32768; i++) nv[i] = sram[i];
      dirty = 1'b0;
    end
  end
  always @(negedge supply_low_in) begin
    if ($time > 0) begin
      busy = 1'b1;
      for (int i = 0; i < 32768; i++) sram[i] = nv[i];
      #(PWRUP_NS);
      busy = 1'b0;
    end
  end
endmodule

// ---- tb_nvsc_ctrl.sv ----
// self-checking bench for the nonvolatile sram pin controller
// assumes nvsc_pkg, nvsc_ctrl and nvsc_mem_model are compiled first
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_nvsc_ctrl
  import nvsc_pkg::*;
;
  localparam int unsigned SAVE_T  = 50;
  localparam int unsigned PWRUP_T = 30;
  logic              clk_in = 1'b0;
  logic              rst_b_in = 1'b0;
  logic              cmd_valid_in = 1'b0;
  logic [1:0]        cmd_op_in = 2'h0;
  logic [ADDR_W-1:0] cmd_addr_in = 15'h0000;
  logic [DATA_W-1:0] cmd_wdata_in = 8'h00;
  logic              supply_low_in = 1'b0;
  logic              cmd_ready_out, rsp_valid_out, busy_out, dev_oe;
  logic              select_n_out, write_strobe_n_out, output_gate_n_out, data_lines_oe_out;
  logic [DATA_W-1:0] rsp_rdata_out, data_lines_out, dev_d;
  logic [DATA_W-1:0] bus_last = 8'h00;
  logic [ADDR_W-1:0] addr_lines_out;
  wire  [DATA_W-1:0] bus = data_lines_oe_out ? data_lines_out : (dev_oe ? dev_d : ~bus_last);
  int                miscompares = 0;
  int                n_tests = 0;

  always #4 clk_in = ~clk_in;
  // undriven lines show the inverse of the last driven value
  always_ff @(posedge clk_in) if (data_lines_oe_out || dev_oe) bus_last <= bus;

  nvsc_ctrl #(.SAVE_CYCLES(SAVE_T), .PWRUP_CYCLES(PWRUP_T)) u_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
    .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in), .cmd_ready_out(cmd_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out), .busy_out(busy_out),
    .supply_low_in(supply_low_in), .select_n_out(select_n_out),
    .write_strobe_n_out(write_strobe_n_out), .output_gate_n_out(output_gate_n_out),
    .addr_lines_out(addr_lines_out), .data_lines_in(bus), .data_lines_out(data_lines_out),
    .data_lines_oe_out(data_lines_oe_out));
  nvsc_mem_model #(.SAVE_NS(300), .RESTORE_NS(19000), .PWRUP_NS(150)) u_mem (
    .select_n_in(select_n_out), .write_strobe_n_in(write_strobe_n_out),
    .output_gate_n_in(output_gate_n_out), .addr_lines_in(addr_lines_out),
    .data_lines_in(bus), .supply_low_in(supply_low_in), .data_out(dev_d), .data_oe_out(dev_oe));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wait_ready(output int n);
    n = 0;
    while (cmd_ready_out !== 1'b1 && n < 4000) begin
      @(negedge clk_in);
      n++;
    end
  endtask

  task automatic do_cmd(input logic [1:0] op, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    int n;
    wait_ready(n);
    `CHK(n < 4000, 1'b1)
    cmd_valid_in = 1'b1;
    cmd_op_in = op;
    cmd_addr_in = a;
    cmd_wdata_in = d;
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    `CHK({busy_out, cmd_ready_out}, 2'h2)
    n = 0;
    while (rsp_valid_out !== 1'b1 && n < 3200) begin
      @(negedge clk_in);
      n++;
    end
    `CHK(n < 3200, 1'b1)
    `CHK({busy_out, cmd_ready_out}, 2'h1)
    q = rsp_rdata_out;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] q;
    do_cmd(OP_READ, a, 8'h00, q);
    `CHK(q, e)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    int n;
    `CHK({select_n_out, write_strobe_n_out, busy_out, cmd_ready_out}, 4'he)
    @(negedge clk_in);
    rst_b_in = 1'b1;
    wait_ready(n);
    `CHK(n >= PWRUP_T, 1'b1)
  endtask

  task automatic t_rw();
    logic [DATA_W-1:0] q;
    do_cmd(OP_WRITE, 15'h0000, 8'ha5, q);
    do_cmd(OP_WRITE, 15'h7fff, 8'h5a, q);
    do_cmd(OP_WRITE, 15'h4e38, 8'h3c, q);
    do_cmd(OP_WRITE, 15'h0e38, 8'hc3, q);
    rd(15'h0000, 8'ha5);
    rd(15'h7fff, 8'h5a);
    rd(15'h4e38, 8'h3c);
    rd(15'h0e38, 8'hc3);
  endtask

  task automatic t_save();
    logic [DATA_W-1:0] q;
    do_cmd(OP_SAVE, 15'h0000, 8'h00, q);
    `CHK(u_mem.nv[15'h7fff], 8'h5a)
    u_mem.sram[15'h0005] = 8'h77;
    do_cmd(OP_SAVE, 15'h0000, 8'h00, q);
    `CHK(u_mem.nv[15'h0005], 8'h77)
  endtask

  task automatic t_restore();
    logic [DATA_W-1:0] q;
    do_cmd(OP_WRITE, 15'h7fff, 8'h11, q);
    do_cmd(OP_RESTORE, 15'h0000, 8'h00, q);
    rd(15'h7fff, 8'h5a);
    do_cmd(OP_RESTORE, 15'h0000, 8'h00, q);
    rd(15'h0005, 8'h77);
    `CHK(u_mem.nv[15'h7fff], 8'h5a)
  endtask

  task automatic t_supply();
    logic [DATA_W-1:0] q;
    int n;
    do_cmd(OP_WRITE, 15'h0100, 8'h99, q);
    supply_low_in = 1'b1;
    repeat (8) @(negedge clk_in);
    `CHK(cmd_ready_out, 1'b0)
    `CHK(u_mem.nv[15'h0100], 8'h99)
    supply_low_in = 1'b0;
    wait_ready(n);
    rd(15'h0100, 8'h99);
    u_mem.sram[15'h0101] = 8'h42;
    supply_low_in = 1'b1;
    repeat (8) @(negedge clk_in);
    `CHK(u_mem.nv[15'h0101], 8'h00)
    supply_low_in = 1'b0;
    wait_ready(n);
    rd(15'h0101, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_in);
    t_reset();
    t_rw();
    t_save();
    t_restore();
    t_supply();
    final_report();
  end

  initial begin
    #400000;
    miscompares++;
    final_report();
  end
endmodule
